// ---- csh_params.svh ----
`ifndef CSH_PARAMS_SVH
`define CSH_PARAMS_SVH
// timing figures in their own units
`define CSH_CLK_MHZ        250
`define CSH_TRIG_MIN_NS    1000
`define CSH_OUT_DLY_MIN_US 200
`define CSH_HAND_GAP_NS    0
`define CSH_CMP_TYP_US     1000
// sweep geometry
`define CSH_NUM_CLASS      9
`define CSH_NUM_POINT      10
`define CSH_CNT_W          20
`endif

// ---- csh_pkg.sv ----
`default_nettype none
package csh_pkg;
   // comparison mode
   typedef enum logic [1:0] {
      CSH_MODE_LEVEL = 2'b00,
      CSH_MODE_SEQ   = 2'b01,
      CSH_MODE_STEP  = 2'b11
   } csh_mode_t;
   // classification result from the comparator
   typedef struct packed {
      logic [8:0] sort_class;   // level bins or sweep points 1..9 failed
      logic       extra_class;  // aux bin or sweep point 10 failed
      logic       reject;       // overall reject
      logic       prim_high;    // above all upper limits
      logic       prim_low;     // below all lower limits
      logic       sec_fail;     // secondary outside limits
   } csh_result_t;
   // handler output lines, active low
   typedef struct packed {
      logic [8:0] sort_class_n;
      logic       extra_class_n;
      logic       overall_reject_n;
      logic       primary_high_n;
      logic       primary_low_n;
      logic       secondary_fail_n;
   } csh_lines_t;
endpackage
`default_nettype wire

// ---- csh_sync.sv ----
`default_nettype none
// two-stage synchroniser for asynchronous pins
module csh_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic core_clk_i, // core clock
   input  wire logic rst_b_i,    // async reset, low
   input  wire logic d_i,        // raw pin
   output var  logic q_o         // synchronised level
);
   logic meta_r;
   // first stage feeds only the second
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_r <= RST_VAL;
         q_o    <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ---- csh_handler_port.sv ----
`include "csh_params.svh"
`default_nettype none
module csh_handler_port #(
   parameter int OUT_DLY_CYC = (`CSH_OUT_DLY_MIN_US * `CSH_CLK_MHZ) // 200us in cycles
) (
   input  wire logic                core_clk_i,        // 250 MHz core clock
   input  wire logic                rst_b_i,           // async reset, low
   input  wire logic                remote_start_n_en_i,     // external trigger selected
   input  wire csh_pkg::csh_mode_t  mode_i,            // level, sequential, stepping
   input  wire logic                remote_start_n_i,  // handler trigger pin
   input  wire logic                panel_lock_n_i,    // handler key lock pin
   input  wire logic [7:0]          keys_i,            // front panel keys
   output var  logic [7:0]          keys_o,            // keys passed to the ui
   input  wire logic                power_fail_i,      // power fail detector
   output var  logic                meas_start_o,      // start pulse to engine
   input  wire logic                analog_end_i,      // one analog step finished
   input  wire logic                sweep_last_i,      // that step was the last
   input  wire logic                cmp_valid_i,       // compare result ready pulse
   input  wire csh_pkg::csh_result_t cmp_res_i,        // compare result
   output var  csh_pkg::csh_lines_t lines_o,           // comparison lines, low true
   output var  logic                analog_done_n_o,   // analog done, low true
   output var  logic                result_valid_n_o,  // result valid, low true
   output var  logic                power_fail_n_o     // alarm, low true
);
   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic trig_s;
   logic lock_s;
   logic trig_d_r;
   logic trig_rise;
   csh_sync #(.RST_VAL(1'b1)) u_trig (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .d_i        (remote_start_n_i),
      .q_o        (trig_s)
   );
   csh_sync #(.RST_VAL(1'b1)) u_lock (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .d_i        (panel_lock_n_i),
      .q_o        (lock_s)
   );
   // edge detector works on the synchronised level only
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trig_d_r <= 1'b1;
      end else begin
         trig_d_r <= trig_s;
      end
   end
   assign trig_rise = trig_s & ~trig_d_r & remote_start_n_en_i;
   assign meas_start_o = trig_rise;

   // ==========================================================
   // key lock and alarm
   // ==========================================================
   // keys gated while lock asserted
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         keys_o <= 8'h00;
      end else begin
         keys_o <= lock_s ? keys_i : 8'h00;
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         power_fail_n_o <= 1'b1;
      end else begin
         power_fail_n_o <= ~power_fail_i;
      end
   end

   // ==========================================================
   // minimum output delay counter
   // ==========================================================
   logic [`CSH_CNT_W-1:0] dly_r;
   logic                  dly_ok;
   localparam logic [`CSH_CNT_W-1:0] DLY_MAX = OUT_DLY_CYC[`CSH_CNT_W-1:0];
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dly_r <= DLY_MAX;
      end else if (trig_rise) begin
         dly_r <= '0;
      end else if (dly_r != DLY_MAX) begin
         dly_r <= dly_r + 1'b1;
      end
   end
   assign dly_ok = (dly_r == DLY_MAX);

   // ==========================================================
   // measurement sequence
   // ==========================================================
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MEAS = 2'b01,
      ST_CMP  = 2'b11,
      ST_DONE = 2'b10
   } csh_state_t;
   csh_state_t st_r;
   logic       analog_flag_r;
   logic       res_flag_r;
   logic       last_seen_r;
   logic       step_mode;
   assign step_mode = (mode_i == csh_pkg::CSH_MODE_STEP);
   // sequencer: measure, then compare
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= ST_IDLE;
      end else if (trig_rise) begin
         st_r <= ST_MEAS;
      end else begin
         case (st_r)
            ST_IDLE: st_r <= ST_IDLE;
            ST_MEAS: begin
               if (analog_end_i && (sweep_last_i || mode_i == csh_pkg::CSH_MODE_LEVEL
                                    || step_mode)) begin
                  st_r <= ST_CMP;
               end
            end
            ST_CMP: begin
               if (cmp_valid_i && dly_ok) begin
                  st_r <= ST_DONE;
               end
            end
            ST_DONE: st_r <= ST_DONE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end
   // remembers that the sweep's last step passed
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         last_seen_r <= 1'b0;
      end else if (trig_rise) begin
         last_seen_r <= 1'b0;
      end else if (st_r == ST_MEAS && analog_end_i && sweep_last_i) begin
         last_seen_r <= 1'b1;
      end
   end
   // analog done after the analog phase
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         analog_flag_r <= 1'b0;
      end else if (trig_rise) begin
         analog_flag_r <= 1'b0;
      end else if (st_r == ST_MEAS && analog_end_i) begin
         analog_flag_r <= step_mode | sweep_last_i
                          | (mode_i == csh_pkg::CSH_MODE_LEVEL);
      end
   end
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         res_flag_r <= 1'b0;
      end else if (trig_rise) begin
         res_flag_r <= 1'b0;
      end else if (st_r == ST_CMP && cmp_valid_i && dly_ok) begin
         res_flag_r <= 1'b1;
      end
   end

   // ==========================================================
   // comparison lines
   // ==========================================================
   csh_pkg::csh_lines_t lines_nxt;
   logic                load_lines;
   // sweep lines load only at cycle end
   assign load_lines = (st_r == ST_CMP) && cmp_valid_i && dly_ok
                       && (mode_i != csh_pkg::CSH_MODE_STEP || last_seen_r);
   // map result onto active low lines
   always_comb begin
      lines_nxt.sort_class_n     = ~cmp_res_i.sort_class;
      // extra line carries point ten in sweep
      lines_nxt.extra_class_n    = ~cmp_res_i.extra_class;
      // reject is the whole part verdict
      lines_nxt.overall_reject_n = ~cmp_res_i.reject;
      lines_nxt.primary_high_n   = ~cmp_res_i.prim_high;
      lines_nxt.primary_low_n    = ~cmp_res_i.prim_low;
      lines_nxt.secondary_fail_n = ~cmp_res_i.sec_fail;
   end
   // idle lines are high, asserted low
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lines_o <= '1;
      end else if (load_lines) begin
         lines_o <= lines_nxt;
      end
   end
   // handler reads lines under result valid
   assign analog_done_n_o  = ~analog_flag_r;
   assign result_valid_n_o = ~res_flag_r;

   // ==========================================================
   // checker helpers
   // ==========================================================
   logic [`CSH_CNT_W-1:0] gap_r;
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gap_r <= '1;
      end else if (trig_rise) begin
         gap_r <= '0;
      end else if (gap_r != '1) begin
         gap_r <= gap_r + 1'b1;
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   sequence start_s;
      trig_rise;
   endsequence
   sequence quiet_s;
      result_valid_n_o [*8];
   endsequence
   sequence load_s;
      load_lines;
   endsequence
   start_clears_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      trig_rise |=> result_valid_n_o && analog_done_n_o)
      else $error("start did not clear status");
   min_delay_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      start_s |=> quiet_s)
      else $error("result valid too soon after start");
   valid_gate_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $fell(result_valid_n_o) |-> $past(cmp_valid_i) && $past(dly_ok))
      else $error("result valid without compare");
   lock_keys_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !lock_s |=> keys_o == 8'h00)
      else $error("key passed while locked");
   alarm_line_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      power_fail_i |=> !power_fail_n_o)
      else $error("alarm not asserted");
   trig_edge_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      meas_start_o |-> remote_start_n_en_i && $past(remote_start_n_i, 2)
                       && !$past(remote_start_n_i, 3))
      else $error("start without rising edge");
   lines_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !load_lines |=> $stable(lines_o))
      else $error("lines changed outside cycle end");
   high_map_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      load_lines && cmp_res_i.prim_high |=> !lines_o.primary_high_n)
      else $error("primary high not driven");
   seq_done_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $fell(analog_done_n_o) && mode_i == csh_pkg::CSH_MODE_SEQ |-> $past(sweep_last_i))
      else $error("analog done before last point");
   gap_delay_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $fell(result_valid_n_o) |-> gap_r > DLY_MAX)
      else $error("result valid before minimum delay");
   valid_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !result_valid_n_o && !trig_rise |=> !result_valid_n_o)
      else $error("result valid dropped without start");
   done_hold_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      !analog_done_n_o && !trig_rise |=> !analog_done_n_o)
      else $error("analog done dropped without start");
   step_done_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      step_mode && st_r == ST_MEAS && analog_end_i && !trig_rise |=> !analog_done_n_o)
      else $error("stepping step without analog done");
   seq_valid_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $fell(result_valid_n_o) && mode_i == csh_pkg::CSH_MODE_SEQ |-> !analog_done_n_o)
      else $error("sequential valid before sweep end");
   meas_restart_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      trig_rise |=> st_r == ST_MEAS)
      else $error("start did not restart sequence");
   keys_open_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      lock_s |=> keys_o == $past(keys_i))
      else $error("key blocked while unlocked");
   low_map_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      load_lines && cmp_res_i.prim_low |=> !lines_o.primary_low_n)
      else $error("primary low not driven");
   sec_map_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      load_lines && cmp_res_i.sec_fail |=> !lines_o.secondary_fail_n)
      else $error("secondary fail not driven");
   class_map_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      load_s |=> lines_o.sort_class_n == ~$past(cmp_res_i.sort_class))
      else $error("class lines do not match result");
   extra_map_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      load_s |=> lines_o.extra_class_n == !$past(cmp_res_i.extra_class))
      else $error("extra line does not match result");
   reject_map_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      load_s |=> lines_o.overall_reject_n == !$past(cmp_res_i.reject))
      else $error("reject line does not match verdict");
   step_lines_a: assert property (
      @(posedge core_clk_i) disable iff (!rst_b_i)
      $changed(lines_o) && $past(step_mode) |-> $past(last_seen_r))
      else $error("stepping lines changed before last step");
endmodule
`default_nettype wire

// ---- csh_handler_model.sv ----
`default_nettype none
// handler side: issues low-going trigger pulses, start on the rising end
module csh_handler_model #(
   parameter int PULSE_CYC = 250 // 1us at 250 MHz
) (
   input  wire logic core_clk_i,       // core clock
   input  wire logic fire_i,           // request one trigger
   output var  logic remote_start_n_o  // trigger pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt   = 0;    // cycles left in the pulse
   logic pin_r = 1'b1; // idle high, so no false edge at start
   assign remote_start_n_o = pin_r;
   // pulse timing, changes on the falling edge
   // pulse held 1us
   always @(negedge core_clk_i) begin
      if (cnt != 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) pin_r <= 1'b1;
      end else if (fire_i) begin
         cnt <= PULSE_CYC;
         pin_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 20;
   logic clk, rst_b, ext_en, start_n, lock_n, pf, aend, last, cval, fire;
   logic mstart, adone_n, rvalid_n, pf_n;
   logic rv_prev = 1'b1;
   logic [7:0] keys, keys_o;
   csh_pkg::csh_mode_t  mode;
   csh_pkg::csh_result_t res;
   csh_pkg::csh_lines_t lines, lp, el;
   csh_pkg::csh_lines_t expq[$];
   int bad_count, tests_run;
   // ==========================================
   // design and handler
   csh_handler_port #(.OUT_DLY_CYC(DLY)) i_csh_handler_port (
      .core_clk_i(clk), .rst_b_i(rst_b), .remote_start_n_en_i(ext_en), .mode_i(mode),
      .remote_start_n_i(start_n), .panel_lock_n_i(lock_n), .keys_i(keys),
      .keys_o(keys_o), .power_fail_i(pf), .meas_start_o(mstart),
      .analog_end_i(aend), .sweep_last_i(last), .cmp_valid_i(cval), .cmp_res_i(res),
      .lines_o(lines), .analog_done_n_o(adone_n), .result_valid_n_o(rvalid_n),
      .power_fail_n_o(pf_n));
   csh_handler_model i_csh_handler_model (
      .core_clk_i(clk), .fire_i(fire), .remote_start_n_o(start_n));
   // ==========================================
   // clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic test_done();
      $display("counts: run %0d bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
         bad_count++;
      end
   endtask
   task automatic hang();
      bad_count++;
      test_done();
   endtask
   // one measurement or stepping step; early sends a compare one cycle short
   task automatic meas(input csh_pkg::csh_mode_t md, input int n, input bit early,
                       input bit fin);
      int c;
      int i;
      mode = md;
      fire <= 1'b1;
      @(negedge clk);
      fire <= 1'b0;
      c = 0;
      while (mstart !== 1'b1 && c < 400) begin
         @(negedge clk);
         c++;
      end
      if (c >= 400) hang();
      c = 1;
      @(negedge clk);
      chk("adone_clr", 1, adone_n);
      chk("rvalid_clr", 1, rvalid_n);
      for (i = 0; i < n; i++) begin
         aend = 1'b1;
         last = fin && (i == n - 1);
         @(negedge clk);
         aend = 1'b0;
         last = 1'b0;
         @(negedge clk);
         c += 2;
         chk("adone", (md == csh_pkg::CSH_MODE_SEQ && i < n - 1), adone_n);
      end
      if (early) begin
         while (c < DLY) begin
            @(negedge clk);
            c++;
         end
         cval = 1'b1;
         res = csh_pkg::csh_result_t'(14'($urandom));
         @(negedge clk);
         cval = 1'b0;
         @(negedge clk);
         c += 2;
         chk("rvalid_early", 1, rvalid_n);
         chk("lines_hold", 32'(lp), 32'(lines));
      end
      while (c < DLY + 2) begin
         @(negedge clk);
         c++;
      end
      res = csh_pkg::csh_result_t'(14'($urandom));
      // stepping lines only move on the last step
      if (md != csh_pkg::CSH_MODE_STEP || fin) lp = csh_pkg::csh_lines_t'(~res);
      expq.push_back(lp);
      cval = 1'b1;
      @(negedge clk);
      cval = 1'b0;
      i = 0;
      while (rvalid_n !== 1'b0 && i < 10) begin
         @(negedge clk);
         i++;
      end
      if (i >= 10) hang();
      chk("valid_lat", 0, i);
      $display("test meas mode %0d steps %0d done", md, n);
   endtask
   // score lines as valid falls
   always @(negedge clk) begin
      if (rv_prev === 1'b1 && rvalid_n === 1'b0) begin
         if (expq.size() == 0) chk("queue", 1, 0);
         else begin
            el = expq.pop_front();
            chk("classes", 32'(el[13:4]), 32'(lines[13:4]));
            chk("flags", 32'(el[3:0]), 32'(lines[3:0]));
         end
      end
      rv_prev = rvalid_n;
   end
   // main sequence
   initial begin
      int k;
      int n;
      rst_b = 1'b0;
      ext_en = 1'b1;
      lock_n = 1'b1;
      keys = 8'h00;
      pf = 1'b0;
      aend = 1'b0;
      last = 1'b0;
      cval = 1'b0;
      fire = 1'b0;
      mode = csh_pkg::CSH_MODE_LEVEL;
      res = '0;
      lp = '1;
      bad_count = 0;
      tests_run = 0;
      void'($urandom(78));
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      chk("rst_lines", 32'h0000_3fff, 32'(lines));
      repeat (3) meas(csh_pkg::CSH_MODE_LEVEL, 1, 1'b0, 1'b1);
      meas(csh_pkg::CSH_MODE_LEVEL, 1, 1'b1, 1'b1);
      meas(csh_pkg::CSH_MODE_SEQ, 3, 1'b0, 1'b1);
      meas(csh_pkg::CSH_MODE_SEQ, 2, 1'b1, 1'b1);
      meas(csh_pkg::CSH_MODE_STEP, 1, 1'b0, 1'b0);
      meas(csh_pkg::CSH_MODE_STEP, 1, 1'b1, 1'b0);
      meas(csh_pkg::CSH_MODE_STEP, 1, 1'b1, 1'b1);
      ext_en = 1'b0;
      fire <= 1'b1;
      @(negedge clk);
      fire <= 1'b0;
      n = 0;
      for (k = 0; k < 300; k++) begin
         @(negedge clk);
         if (mstart === 1'b1) n++;
      end
      chk("no_start", 0, n);
      ext_en = 1'b1;
      $display("test trigger disabled done");
      lock_n = 1'b0;
      keys = 8'($urandom) | 8'h01; // never zero, so the lock shows
      repeat (4) @(negedge clk);
      chk("keys_locked", 0, keys_o);
      lock_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("keys_open", keys, keys_o);
      $display("test panel lock done");
      pf = 1'b1;
      repeat (2) @(negedge clk);
      chk("alarm_on", 0, pf_n);
      pf = 1'b0;
      repeat (2) @(negedge clk);
      chk("alarm_off", 1, pf_n);
      $display("test power fail done");
      test_done();
   end
endmodule
`default_nettype wire
